//--- hdl/sfsp_status_protect.sv
/*
  status register and write protection of a serial flash: serial front end
  on the link clock, status, latch, lock and timed write cycle on ref_clk.
  assumes the link clock stands still while chip select is high, and that an
  array sequencer outside asks for program and erase grants and reports done.
*/
`timescale 1ns/1ps
module sfsp_status_protect
  import sfsp_pkg::*;
#(
  parameter int TW_CYCLES = SFSP_TW_CYCLES
) (
  // system clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // serial link pins
  input  wire logic       link_clk,
  input  wire logic       cs_n,
  input  wire logic       mosi,
  output logic            miso_q,
  output logic            miso_oe_q,
  input  wire logic       protect_pin_n,
  // array sequencer requests
  input  wire logic       op_req,
  input  wire logic [1:0] op_kind,
  input  wire logic       op_in_prot,
  input  wire logic       op_done,
  output logic            op_grant_q,
  output logic            op_refused_q,
  // status view
  output logic            busy_flag_q,
  output logic            write_arm_latch_q,
  output logic [2:0]      prot_level_q,
  output logic            status_lock_bit_q,
  output logic            hard_locked_q
);

  // link domain state
  logic       fresh_q;
  logic [4:0] bit_cnt_q;
  logic [4:0] bit_cnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] opcode_q;
  logic       frame_tgl_q;
  logic       read_on_q;
  logic [7:0] stat_link;

  // system domain state
  logic        cs_s;
  logic        cs_d_q;
  logic        wp_s;
  logic        tgl_s;
  logic        tgl_seen_q;
  logic        frame_new;
  logic [7:0]  fr_op;
  logic [4:0]  fr_cnt;
  logic [7:0]  fr_data;
  sfsp_state_t state_q;
  sfsp_state_t state_d;
  logic [SFSP_TW_W-1:0] tw_cnt_q;
  logic        tw_last;
  logic [7:0]  wr_val_q;
  logic        lock_now;
  logic        arm_ok;
  logic        disarm_ok;
  logic        stwr_ok;
  logic        op_ok;
  logic        op_blocked;
  logic [7:0]  stat_byte_q;

  // exact frame length check, shared by every write-class instruction
  function automatic logic frame_is(input logic [4:0] cnt, input logic [4:0] need);
    frame_is = (cnt == need);
  endfunction

  // true when a protected target or a nonzero level must stop the operation
  function automatic logic prot_blocks(input logic [1:0] kind, input logic in_prot,
                                       input logic [2:0] level);
    if (kind == SFSP_K_CHIP)
      prot_blocks = (level != 3'h0);
    else
      prot_blocks = in_prot;
  endfunction

  // ---- link clock domain ----

  // count of pulses in the frame; fresh marks a frame with no pulse yet
  // at the top the count wraps inside its last byte: long status reads keep
  // cycling bits, and the count never again matches a frame length
  always_comb begin
    if (fresh_q)
      bit_cnt_d = 5'h01;
    else if (bit_cnt_q != SFSP_BITS_SAT)
      bit_cnt_d = bit_cnt_q + 5'h01;
    else
      bit_cnt_d = {bit_cnt_q[4:3], 3'h0}; // R5
    shift_d = {shift_q[6:0], mosi}; // R25
  end

  // set while deselected, so the first pulse of a frame restarts the count
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n)
      fresh_q <= 1'b1;
    else
      fresh_q <= 1'b0;
  end

  // bits latched on the rising edge, msb first
  always_ff @(posedge link_clk) begin
    bit_cnt_q <= bit_cnt_d;
    shift_q   <= shift_d; // R25
  end

  // instruction byte held after its eighth bit
  always_ff @(posedge link_clk) begin
    if (bit_cnt_d == SFSP_BITS_CMD)
      opcode_q <= shift_d;
  end

  // frame event toggle; counts and bytes stay still until the next frame
  always_ff @(posedge link_clk or posedge reset) begin
    if (reset)
      frame_tgl_q <= 1'b0;
    else if (fresh_q)
      frame_tgl_q <= ~frame_tgl_q;
  end

  // status read armed once its instruction byte is in
  always_ff @(posedge link_clk or posedge cs_n) begin
    if (cs_n)
      read_on_q <= 1'b0;
    else if (bit_cnt_d == SFSP_BITS_CMD && shift_d == SFSP_OP_STRD)
      read_on_q <= 1'b1; // R4
  end

  // live status into the link domain; bits are independent flags
  sfsp_sync #(
    .W       (8),
    .RST_VAL (8'h00)
  ) u_stat_sync (
    .clk   (link_clk),
    .reset (1'b0),
    .d     (stat_byte_q),
    .q     (stat_link)
  );

  // output shifts on the falling edge, byte repeats with fresh status
  always_ff @(negedge link_clk or posedge cs_n) begin
    if (cs_n) begin
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= read_on_q;
      miso_q    <= stat_link[3'h7 - bit_cnt_q[2:0]]; // R5 R25
    end
  end

  // ---- system clock domain ----

  // pins and the frame toggle pass two flops before use
  sfsp_sync #(
    .W       (1),
    .RST_VAL (8'h01)
  ) u_cs_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (cs_n),
    .q     (cs_s)
  );

  sfsp_sync #(
    .W       (1),
    .RST_VAL (8'h01)
  ) u_wp_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (protect_pin_n),
    .q     (wp_s)
  );

  sfsp_sync #(
    .W       (1),
    .RST_VAL (8'h00)
  ) u_tgl_sync (
    .clk   (ref_clk),
    .reset (reset),
    .d     (frame_tgl_q),
    .q     (tgl_s)
  );

  // select rise after a frame that carried pulses; a pulseless frame is ignored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_d_q     <= 1'b1;
      tgl_seen_q <= 1'b0;
    end else begin
      cs_d_q <= cs_s;
      if (frame_new)
        tgl_seen_q <= tgl_s;
    end
  end

  // captured words are stable here since the link clock is idle
  always_comb begin
    frame_new = cs_s && !cs_d_q && (tgl_s != tgl_seen_q);
    fr_op     = opcode_q;
    fr_cnt    = bit_cnt_q;
    fr_data   = shift_q;
  end

  // lock state and acceptance decisions
  always_comb begin
    lock_now   = status_lock_bit_q && !wp_s; // R11 R19 R20
    arm_ok     = frame_new && fr_op == SFSP_OP_ARM
                 && frame_is(fr_cnt, SFSP_BITS_CMD)
                 && state_q == SFSP_S_IDLE; // R23 R24
    disarm_ok  = frame_new && fr_op == SFSP_OP_DISARM
                 && frame_is(fr_cnt, SFSP_BITS_CMD)
                 && state_q == SFSP_S_IDLE; // R1 R24
    stwr_ok    = frame_new && fr_op == SFSP_OP_STWR
                 && frame_is(fr_cnt, SFSP_BITS_WR) // R15 R24
                 && write_arm_latch_q // R8 R12 R17 R18
                 && !lock_now // R11
                 && state_q == SFSP_S_IDLE;
    op_blocked = prot_blocks(op_kind, op_in_prot, prot_level_q); // R9 R10 R21
    op_ok      = op_req && write_arm_latch_q && !op_blocked // R8
                 && state_q == SFSP_S_IDLE && !stwr_ok;
  end

  // write cycle timer end
  always_comb begin
    tw_last = (tw_cnt_q == SFSP_TW_W'(TW_CYCLES - 1));
  end

  // control sequence: idle, timed status write, array operation
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFSP_S_IDLE: begin
        if (stwr_ok)
          state_d = SFSP_S_WRS; // R16
        else if (op_ok)
          state_d = SFSP_S_OPS;
      end
      SFSP_S_WRS: begin
        if (tw_last)
          state_d = SFSP_S_IDLE;
      end
      SFSP_S_OPS: begin
        if (op_done)
          state_d = SFSP_S_IDLE;
      end
      default: state_d = SFSP_S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset)
      state_q <= SFSP_S_IDLE;
    else
      state_q <= state_d;
  end

  // self-timed write cycle length
  always_ff @(posedge ref_clk) begin
    if (reset || state_q != SFSP_S_WRS)
      tw_cnt_q <= '0;
    else
      tw_cnt_q <= tw_cnt_q + SFSP_TW_W'(1); // R16
  end

  // busy for the whole write or array cycle
  always_ff @(posedge ref_clk) begin
    if (reset)
      busy_flag_q <= 1'b0;
    else
      busy_flag_q <= (state_d != SFSP_S_IDLE); // R7
  end

  // new value held until the write cycle commits it
  always_ff @(posedge ref_clk) begin
    if (reset)
      wr_val_q <= 8'h00;
    else if (stwr_ok)
      wr_val_q <= fr_data; // R13
  end

  // non-volatile bits change only when a status write completes
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      prot_level_q      <= SFSP_PL_RST;
      status_lock_bit_q <= SFSP_LOCK_RST; // R22
    end else if (state_q == SFSP_S_WRS && tw_last) begin
      prot_level_q      <= wr_val_q[SFSP_BIT_PL2:SFSP_BIT_PL0]; // R9 R14
      status_lock_bit_q <= wr_val_q[SFSP_BIT_LOCK];
    end
  end

  // arm latch; a set in the same cycle as a clear wins
  always_ff @(posedge ref_clk) begin
    if (reset)
      write_arm_latch_q <= SFSP_ARM_RST; // R3
    else if (arm_ok)
      write_arm_latch_q <= 1'b1; // R23
    else if (disarm_ok)
      write_arm_latch_q <= 1'b0; // R1 R3
    else if (state_q == SFSP_S_WRS && tw_last)
      write_arm_latch_q <= 1'b0; // R3 R16
    else if (state_q == SFSP_S_OPS && op_done)
      write_arm_latch_q <= 1'b0; // R3
  end

  // hard lock view
  always_ff @(posedge ref_clk) begin
    if (reset)
      hard_locked_q <= 1'b0;
    else
      hard_locked_q <= lock_now; // R19 R20
  end

  // one-cycle answers to the array sequencer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      op_grant_q   <= 1'b0;
      op_refused_q <= 1'b0;
    end else begin
      op_grant_q   <= op_ok;
      op_refused_q <= op_req && !op_ok; // R8 R21
    end
  end

  // status byte as the host sees it; b6 and b5 read zero
  always_ff @(posedge ref_clk) begin
    if (reset)
      stat_byte_q <= 8'h00;
    else
      stat_byte_q <= {status_lock_bit_q, 2'b00, prot_level_q,
                      write_arm_latch_q, busy_flag_q}; // R14 R26
  end

endmodule

//--- shared/sfsp_pkg.sv
/*
  constants, encodings and state types of the serial flash status and
  write-protection block, shared by the design and the bench.
  assumes the serial link shifts msb first and frames are bounded by an
  active-low chip select; the system clock runs at 40 MHz.
*/
// Function
// [R1] a completed disarm instruction clears the write arm latch
// [R2] host sends disarm as one instruction byte inside one select frame
// [R3] arm latch cleared at reset and after disarm, status write and array ops
// [R4] status read is answered at any time, even during busy cycles
// [R5] status read repeats the live status byte while the host keeps clocking
// [R6] host should poll busy and wait before sending new instructions
// [R7] busy flag is 1 during status write, program or erase, else 0
// [R8] with arm latch 0, status write, program and erase are refused
// [R9] protect level changes only by status write; nonzero blocks protected region
// [R10] full chip clear runs only when all protect level bits are zero
// [R11] lock bit set and protect pin low gives hard lock; status write refused
// [R12] status write needs a prior arm instruction that set the arm latch
// [R13] host sends status write as instruction byte then exactly one data byte
// [R14] status write leaves b6 b5 b1 b0; b6 and b5 read zero
// [R15] select must rise right after the eighth data bit, else write discarded
// [R16] valid status write starts timed cycle with busy; end clears busy and arm
// [R17] lock bit 0: status writes allowed when armed, whatever the protect pin
// [R18] lock bit 1 and pin high: status writes allowed when armed
// [R19] hard lock entered whichever comes last: lock bit set or pin low
// [R20] hard lock left only when the protect pin returns high
// [R21] in both lock states protected region refuses program and erase
// [R22] lock bit starts cleared so hard lock is unreachable at first
// [R23] a completed arm instruction sets the write arm latch
// [R24] arm, disarm and status write need whole bytes of clocks, else rejected
// [R25] instruction, status and data bytes travel msb first
// [R26] status byte: busy b0, arm b1, protect level b4..b2, lock b7
package sfsp_pkg;

  // instruction codes recognised by this block
  localparam logic [7:0] SFSP_OP_ARM    = 8'h06;
  localparam logic [7:0] SFSP_OP_DISARM = 8'h04;
  localparam logic [7:0] SFSP_OP_STRD   = 8'h05;
  localparam logic [7:0] SFSP_OP_STWR   = 8'h01;

  // status byte layout
  localparam int SFSP_BIT_BUSY = 0;
  localparam int SFSP_BIT_ARM  = 1;
  localparam int SFSP_BIT_PL0  = 2;
  localparam int SFSP_BIT_PL2  = 4;
  localparam int SFSP_BIT_LOCK = 7;

  // reset and delivery values
  localparam logic       SFSP_ARM_RST  = 1'b0;
  localparam logic       SFSP_LOCK_RST = 1'b0;
  localparam logic [2:0] SFSP_PL_RST   = 3'h0;

  // frame lengths in link clock pulses
  localparam logic [4:0] SFSP_BITS_CMD = 5'h08;
  localparam logic [4:0] SFSP_BITS_WR  = 5'h10;
  localparam logic [4:0] SFSP_BITS_SAT = 5'h1F;

  // self-timed status write cycle
  // kept in ns so the sum stays well inside 32 bits
  localparam int SFSP_CLK_PERIOD_NS = 25;
  localparam int SFSP_T_W_NS        = 5000000;
  localparam int SFSP_TW_CYCLES     =
    (SFSP_T_W_NS + SFSP_CLK_PERIOD_NS - 1) / SFSP_CLK_PERIOD_NS;
  localparam int SFSP_TW_W          = 24;

  // array operation kinds from the array sequencer
  typedef enum logic [1:0] {
    SFSP_K_PAGE  = 2'h0,
    SFSP_K_BLOCK = 2'h1,
    SFSP_K_CHIP  = 2'h2
  } sfsp_kind_t;

  // control states, one-hot
  typedef enum logic [2:0] {
    SFSP_S_IDLE = 3'b001,
    SFSP_S_WRS  = 3'b010,
    SFSP_S_OPS  = 3'b100
  } sfsp_state_t;

endpackage

//--- hdl/sfsp_sync.sv
/*
  two flip-flop level synchroniser of parameter width.
  assumes each bit is an independent level; the reset is synchronous.
*/
`timescale 1ns/1ps
module sfsp_sync #(
  parameter int         W       = 1,
  parameter logic [7:0] RST_VAL = 8'h00
) (
  // clock and reset of the receiving domain
  input  wire logic         clk,
  input  wire logic         reset,
  // levels
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds the second only
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST_VAL[W-1:0];
      q      <= RST_VAL[W-1:0];
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule

//--- verif/sfsp_status_protect_monitor.sv
/*
  port checker of the status and protect block.
  assumes it is bound to the top module; all checks on ref_clk.
*/
`timescale 1ns/1ps
module sfsp_status_protect_monitor #(
  parameter int TW_CYCLES = 20
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // pin and array requests
  input wire logic       protect_pin_n,
  input wire logic       op_req,
  input wire logic [1:0] op_kind,
  input wire logic       op_in_prot,
  input wire logic       op_done,
  // answers and status
  input wire logic       op_grant_q,
  input wire logic       op_refused_q,
  input wire logic       busy_flag_q,
  input wire logic       write_arm_latch_q,
  input wire logic [2:0] prot_level_q,
  input wire logic       status_lock_bit_q,
  input wire logic       hard_locked_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  // request answers, one cycle after the request
  a_unarmed_refuse: assert property (op_req && !write_arm_latch_q |=> op_refused_q && !op_grant_q)
    else $error("unarmed request not refused");
  a_grant_busy: assert property (op_grant_q |-> busy_flag_q)
    else $error("grant without busy");
  a_done_idle: assert property (op_done && busy_flag_q |=> !busy_flag_q && !write_arm_latch_q)
    else $error("busy or arm left after done");
  a_chip_level: assert property (op_req && op_kind == 2'h2 && prot_level_q != 3'h0 |=> op_refused_q)
    else $error("chip clear not refused");
  a_prot_region: assert property (op_req && op_in_prot && prot_level_q != 3'h0 |=> op_refused_q)
    else $error("protected region not refused");
  // lock behaviour; pin sync and the hard lock flop add three cycles
  a_hard_frozen: assert property (hard_locked_q |=> $stable({status_lock_bit_q, prot_level_q}))
    else $error("status bits changed in hard lock");
  a_pin_release: assert property (protect_pin_n [*4] |-> !hard_locked_q)
    else $error("hard lock kept with pin high");
  a_hard_cause: assert property (hard_locked_q |-> status_lock_bit_q)
    else $error("hard lock without lock bit");
  // bits change only as a write cycle ends
  a_level_source: assert property (!$stable({status_lock_bit_q, prot_level_q}) |-> $fell(busy_flag_q))
    else $error("status bits changed outside write end");

  // length of a status write cycle; a busy rise without a grant is a write
  logic busy_d_q;
  logic wr_on_q;
  int   wr_len_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy_d_q <= 1'b0;
      wr_on_q  <= 1'b0;
      wr_len_q <= 0;
    end else begin
      busy_d_q <= busy_flag_q;
      if (busy_flag_q && !busy_d_q && !op_grant_q) begin
        wr_on_q  <= 1'b1;
        wr_len_q <= 1;
      end else if (!busy_flag_q) begin
        wr_on_q  <= 1'b0;
      end else if (wr_on_q) begin
        wr_len_q <= wr_len_q + 1;
      end
    end
  end
  a_write_length: assert property (wr_on_q && !busy_flag_q |-> wr_len_q == TW_CYCLES)
    else $error("status write cycle length wrong");

  c_grant: cover property (op_grant_q);
  c_refused: cover property (op_refused_q);
  c_hard: cover property ($rose(hard_locked_q));
endmodule

//--- verif/sfsp_host_model.sv
/*
  host serial master model: link clock, select and data out.
  assumes transfers are called one at a time; clock idles low.
*/
`timescale 1ns/1ps
module sfsp_host_model (
  // link outputs
  output logic     link_clk,
  output logic     cs_n,
  output logic     mosi,
  // link inputs
  input wire logic miso_q,
  input wire logic miso_oe_q
);
  initial begin
    link_clk = 1'b0;
    mosi     = 1'b0;
    // rise after time zero so the select edge reaches the frame flops
    #1 cs_n = 1'b1;
  end

  // one frame of n pulses; rx keeps the last byte read back
  task automatic xfer(input int n, input logic [15:0] tx, output logic [7:0] rx);
    rx   = 8'h00;
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = tx[15 - (i % 16)];
      #7.5 link_clk = 1'b1;
      // a released line reads as the inverse, so a missing enable shows up
      if (i >= 8) rx = {rx[6:0], miso_oe_q ? miso_q : ~miso_q};
      #7.5 link_clk = 1'b0;
    end
    #7.5 cs_n = 1'b1;
    mosi = ~mosi;
    // gap covers the 150 ns minimum between frames
    #200;
  endtask
endmodule

//--- verif/sfsp_status_protect_bench.sv
/*
  bench of the status and protect block with the host model.
  assumes the write cycle is shortened to 20 cycles.
*/
`timescale 1ns/1ps
module sfsp_status_protect_bench;
  import sfsp_pkg::*;
  localparam int TW = 20;
  logic        ref_clk = 1'b0;
  logic        reset = 1'b0;
  logic        link_clk, cs_n, mosi, miso_q, miso_oe_q;
  logic        protect_pin_n = 1'b1;
  logic        op_req = 1'b0;
  logic        op_in_prot = 1'b0;
  logic        op_done = 1'b0;
  logic [1:0]  op_kind = 2'h0;
  logic        op_grant_q, op_refused_q, busy_flag_q, write_arm_latch_q;
  logic        status_lock_bit_q, hard_locked_q;
  logic [2:0]  prot_level_q;
  logic [7:0]  rx, d;
  logic [31:0] seed = 32'h44C2;
  logic        e_lock = 1'b0;
  logic        e_arm = 1'b0;
  logic [2:0]  e_lvl = 3'h0;
  int          num_errors = 0;
  int          compares = 0;

  always #12.5 ref_clk = ~ref_clk;

  sfsp_status_protect #(.TW_CYCLES(TW)) i_sfsp_status_protect (.ref_clk, .reset,
    .link_clk, .cs_n, .mosi, .miso_q, .miso_oe_q, .protect_pin_n, .op_req, .op_kind,
    .op_in_prot, .op_done, .op_grant_q, .op_refused_q, .busy_flag_q,
    .write_arm_latch_q, .prot_level_q, .status_lock_bit_q, .hard_locked_q);
  sfsp_host_model i_sfsp_host_model (.link_clk, .cs_n, .mosi, .miso_q, .miso_oe_q);

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // expected status byte from the bench's own state
  function automatic logic [7:0] ex(input logic b);
    return {e_lock, 2'h0, e_lvl, e_arm, b};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    if (num_errors == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input int n, input logic [15:0] w);
    i_sfsp_host_model.xfer(n, w, rx);
  endtask
  // status over the link, and at the ports when idle
  task automatic look(input int n, input logic b);
    cmd(n, {SFSP_OP_STRD, 8'h00});
    chk("link status", ex(b), rx);
    if (!b) chk("port status", ex(1'b0), {status_lock_bit_q, 2'h0, prot_level_q,
      write_arm_latch_q, busy_flag_q});
  endtask
  // arm then status write of n pulses
  task automatic swr(input logic [7:0] v, input int n, input logic ok);
    cmd(8, {SFSP_OP_ARM, 8'h00});
    e_arm = 1'b1;
    cmd(n, {SFSP_OP_STWR, v});
    if (ok) begin
      look(16, 1'b1);
      for (int i = 0; i < 60 && busy_flag_q !== 1'b0; i++) @(posedge ref_clk);
      e_arm  = 1'b0;
      e_lock = v[7];
      e_lvl  = v[4:2];
    end
    look(24, 1'b0);
    if (!ok) begin
      cmd(8, {SFSP_OP_DISARM, 8'h00});
      e_arm = 1'b0;
      look(24, 1'b0);
    end
  endtask
  // one array request; g says whether a grant is due
  task automatic op(input logic [1:0] k, input logic p, input logic g);
    @(posedge ref_clk);
    op_kind    <= k;
    op_in_prot <= p;
    op_req     <= 1'b1;
    @(posedge ref_clk);
    op_req <= 1'b0;
    // the answers stand for the one cycle after the request edge
    #1 chk("grant", {7'h0, g}, {7'h0, op_grant_q});
    chk("refused", {7'h0, !g}, {7'h0, op_refused_q});
    if (g) begin
      repeat (3) @(posedge ref_clk);
      op_done <= 1'b1;
      @(posedge ref_clk);
      op_done <= 1'b0;
      e_arm = 1'b0;
    end
    look(24, 1'b0);
  endtask
  task automatic pin(input logic v);
    @(posedge ref_clk);
    protect_pin_n <= v;
    repeat (5) @(posedge ref_clk);
    #1 chk("hard lock", {7'h0, e_lock & !v}, {7'h0, hard_locked_q});
  endtask

  // hang guard, far beyond the expected run
  initial begin
    #300us;
    num_errors++;
    end_sim();
  end

  initial begin
    // raised at time zero by a nonblocking assignment so the link side sees a reset edge
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    look(24, 1'b0);
    cmd(9, {SFSP_OP_ARM, 8'h00});
    look(24, 1'b0);
    cmd(16, {SFSP_OP_STWR, 8'hFF});
    look(24, 1'b0);
    swr(8'h63, 16, 1'b1);
    swr(8'h9C, 15, 1'b0);
    for (int j = 0; j < 4; j++) begin
      seed = xs(seed);
      swr(seed[7:0] & 8'h7F, 16, 1'b1);
    end
    swr(8'h00, 16, 1'b1);
    seed = xs(seed);
    op(seed[1:0] % 3, 1'b0, 1'b0);
    cmd(8, {SFSP_OP_ARM, 8'h00});
    e_arm = 1'b1;
    op(2'h2, 1'b0, 1'b1);
    swr(8'h08, 16, 1'b1);
    cmd(8, {SFSP_OP_ARM, 8'h00});
    e_arm = 1'b1;
    op(2'h2, 1'b0, 1'b0);
    op(2'h0, 1'b1, 1'b0);
    op(2'h1, 1'b0, 1'b1);
    swr(8'h94, 16, 1'b1);
    pin(1'b0);
    swr(8'h00, 16, 1'b0);
    pin(1'b1);
    swr(8'h00, 16, 1'b1);
    pin(1'b0);
    swr(8'h80, 16, 1'b1);
    pin(1'b0);
    pin(1'b1);
    end_sim();
  end
endmodule

bind sfsp_status_protect sfsp_status_protect_monitor #(.TW_CYCLES(TW_CYCLES)) i_mon (.ref_clk,
  .reset, .protect_pin_n, .op_req, .op_kind, .op_in_prot, .op_done, .op_grant_q,
  .op_refused_q, .busy_flag_q, .write_arm_latch_q, .prot_level_q, .status_lock_bit_q,
  .hard_locked_q);
